// *** core/gpio_map.svh ***
// Register offsets, reset values and fixed pin numbers of the GPIO block
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
`define GP_OUT      12'h000
`define GP_MASK     12'h004
`define GP_MPORT    12'h008
`define GP_SET      12'h00c
`define GP_CLR      12'h010
`define GP_NOT      12'h014
`define GP_DIR      12'h018
`define GP_DIRSET   12'h01c
`define GP_DIRCLR   12'h020
`define GP_DIRNOT   12'h024
`define GP_PIN      12'h028
`define GP_GPEN     12'h02c
`define GP_FIXEN    12'h030
`define GP_ANA      12'h034
`define GP_FDIV     12'h038
`define GP_MOV_BASE 5'h02
`define GP_TSEL_BASE 6'h06
`define GP_CFG_BASE 5'h01
`define GPEN_RST    32'hffff_ffd3
`define FIXEN_RST   32'h0000_002c
`define FDIV_RST    32'h0000_0000
`define TSEL_RST    2'h3
`define MOV_NONE    8'hff
`define OD_PIN_A    5'h0a
`define OD_PIN_B    5'h0b
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// *** core/gpio_pkg.sv ***
// Types shared by the GPIO block modules
package gpio_pkg;
	typedef struct packed {
		logic [1:0] i2c;
		logic [1:0] fclk;
		logic [1:0] fsamp;
		logic       hys;
		logic       inv;
		logic       rep;
		logic       od;
		logic       pd;
		logic       pu;
	} pin_cfg_s;
	typedef logic [31:0][1:0] pin2_t;
endpackage

// *** core/filt_tick_if.sv ***
// Divided filter clock ticks from the divider to the input filter
`timescale 1ns/100ps
interface filt_tick_if;
	logic [3:0] tick;
	modport div (output tick);
	modport filt (input tick);
endinterface

// *** core/filter_clock_divider.sv ***
// Four programmable dividers giving one-cycle filter sample ticks
`timescale 1ns/100ps
module filter_clock_divider
	import gpio_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [31:0] fdiv,
	filt_tick_if.div         fi
);
	typedef struct packed {
		logic [3:0][7:0] cnt;
		logic [3:0]      tick;
	} div_s;
	div_s st_q;
	div_s st_d;

	always_comb
	begin
		st_d = st_q;
		for (int k = 0; k < 4; k++)
		begin
			st_d.tick[k] = (st_q.cnt[k] == fdiv[8*k +: 8]);
			st_d.cnt[k] = st_d.tick[k] ? 8'h00 : st_q.cnt[k] + 8'h01;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign fi.tick = st_q.tick;
endmodule

// *** core/glitch_filter.sv ***
// Per-pin glitch filter: a level passes after N stable sample ticks
`timescale 1ns/100ps
module glitch_filter
	import gpio_pkg::*;
(
	input  wire logic [31:0] raw,
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire pin2_t       samp,
	input  wire pin2_t       csel,
	filt_tick_if.filt        fi,
	output logic      [31:0] filt
);
	typedef struct packed {
		logic [31:0][1:0] cnt;
		logic [31:0]      q;
	} flt_s;
	flt_s st_q;
	flt_s st_d;

	always_comb
	begin
		st_d = st_q;
		for (int p = 0; p < 32; p++)
		begin
			if (samp[p] == 2'h0)
			begin
				st_d.q[p] = raw[p];
				st_d.cnt[p] = 2'h0;
			end
			else if (raw[p] == st_q.q[p])
				st_d.cnt[p] = 2'h0;
			else if (fi.tick[csel[p]])
			begin
				// Level differs: count stable samples before accepting it
				if (st_q.cnt[p] + 2'h1 == samp[p])
				begin
					st_d.q[p] = raw[p];
					st_d.cnt[p] = 2'h0;
				end
				else
					st_d.cnt[p] = st_q.cnt[p] + 2'h1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign filt = st_q.q;
endmodule

// *** core/gpio_pin_config_switch_matrix.sv ***
// GPIO port, per-pin configuration and pin function router with AXI4-Lite access
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "gpio_map.svh"
// Operation
// - Any unclaimed pin switches between input and output by a direction bit.
// - One write drives several outputs high or low, touching only selected bits.
// - Whole port output value is written in one access.
// - Masked, set-only and clear-only writes act across the whole port.
// - Direction bits have set, clear and toggle writes per pin.
// - Reset: all pins inputs with pull-up, except two open-drain pins.
// - Reset routes port function to pins, except debug and reset pins.
// - Register reads respond one cycle after the address; writes respond two cycles after address and data.
// - Each port bit is tied to one pin, only enabled or disabled.
// - Each pin except the two open-drain pins has independent pull-up and pull-down enables.
// - Pseudo open-drain: output only pulls low, otherwise released.
// - Input filter with selectable constant and filter clock, bypassable.
// - Per-pin inversion of the sampled input.
// - Repeater keeps the pin weakly at its last level via pulls.
// - Per-pin hysteresis enable.
// - Open-drain pins select plain, standard/fast I2C or fast-plus I2C driver.
// - Analog mode disconnects the pin's digital input and output.
// - Movable functions go to any pin.
// - Timer functions pick one of 2 or 3 candidate pins by a field.
// - Fixed functions only enable or disable; disabled frees pin for movables.
module gpio_pin_config_switch_matrix
	import gpio_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [31:0]       pad_in,
	output logic [31:0]            pad_out,
	output logic [31:0]            pad_oe,
	output logic [31:0]            pad_pu,
	output logic [31:0]            pad_pd,
	output logic [31:0]            pad_hys,
	output logic [31:0]            pad_ana,
	output logic [31:0]            fix_en,
	output logic [3:0]             od_i2c_mode,
	input  wire logic [7:0]        mov_out,
	input  wire logic [7:0]        mov_oe,
	output logic [7:0]             mov_in,
	input  wire logic [3:0]        tmr_out,
	input  wire logic [3:0]        tmr_oe,
	output logic [3:0]             tmr_in
);
	typedef struct packed {
		logic [31:0]         out;
		logic [31:0]         mask;
		logic [31:0]         dir;
		logic [31:0]         gpen;
		logic [31:0]         fixen;
		logic [31:0]         ana;
		logic [31:0]         fdiv;
		pin_cfg_s [31:0]     cfg;
		logic [7:0][7:0]     mov;
		logic [3:0][1:0]     tsel;
		logic [31:0]         s1;
		logic [31:0]         s2;
		logic [31:0]         s3;
		logic [31:0]         lvl;
		logic                aw_have;
		logic [11:0]         aw_addr;
		logic                w_have;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [1:0]          rresp;
		logic [31:0]         rdata;
		logic [31:0]         pad_out;
		logic [31:0]         pad_oe;
		logic [31:0]         pad_pu;
		logic [31:0]         pad_pd;
		logic [31:0]         pad_hys;
		logic [3:0]          i2c;
		logic [7:0]          mov_in;
		logic [3:0]          tmr_in;
	} st_s;

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a[11:2] == off[11:2]);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// Candidate pins of each timer function; bit 5 marks a connected choice
	function automatic logic [5:0] tmr_cand(input logic [1:0] k, input logic [1:0] sel);
		case ({k, sel})
			4'h0: tmr_cand = {1'b1, 5'h04};
			4'h1: tmr_cand = {1'b1, 5'h0c};
			4'h2: tmr_cand = {1'b1, 5'h14};
			4'h4: tmr_cand = {1'b1, 5'h06};
			4'h5: tmr_cand = {1'b1, 5'h0e};
			4'h8: tmr_cand = {1'b1, 5'h08};
			4'h9: tmr_cand = {1'b1, 5'h10};
			4'ha: tmr_cand = {1'b1, 5'h18};
			4'hc: tmr_cand = {1'b1, 5'h09};
			4'hd: tmr_cand = {1'b1, 5'h12};
			default: tmr_cand = 6'h00;
		endcase
	endfunction

	function automatic st_s st_reset();
		st_reset = '0;
		st_reset.gpen = `GPEN_RST;
		st_reset.fixen = `FIXEN_RST;
		st_reset.fdiv = `FDIV_RST;
		for (int p = 0; p < 32; p++)
			st_reset.cfg[p].pu = (p != `OD_PIN_A) && (p != `OD_PIN_B);
		for (int k = 0; k < 8; k++)
			st_reset.mov[k] = `MOV_NONE;
		for (int k = 0; k < 4; k++)
			st_reset.tsel[k] = `TSEL_RST;
		st_reset.awready = 1'b1;
		st_reset.wready = 1'b1;
		st_reset.arready = 1'b1;
	endfunction

	st_s          st_q;
	st_s          st_d;
	logic [31:0]  filt;
	logic [31:0]  pin_val;
	logic [31:0]  wm;
	logic [5:0]   tc;
	logic         o;
	logic         e;
	pin2_t        samp;
	pin2_t        csel;
	filt_tick_if  fti ();

	// -------------------------------------------------------------
	// Input filter and its sample clocks
	// -------------------------------------------------------------
	filter_clock_divider filter_clock_divider_i (
		.clk     (clk),
		.sys_rst (sys_rst),
		.fdiv    (st_q.fdiv),
		.fi      (fti)
	);

	glitch_filter glitch_filter_i (
		.raw     (st_q.lvl),
		.clk     (clk),
		.sys_rst (sys_rst),
		.samp    (samp),
		.csel    (csel),
		.fi      (fti),
		.filt    (filt)
	);

	always_comb
	begin
		for (int p = 0; p < 32; p++)
		begin
			samp[p] = st_q.cfg[p].fsamp;
			csel[p] = st_q.cfg[p].fclk;
			pin_val[p] = ~st_q.ana[p] & (filt[p] ^ st_q.cfg[p].inv);
		end
	end

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		wm = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}}, {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
		tc = 6'h00;
		o = 1'b0;
		e = 1'b0;

		// Pin synchroniser: a change counts once stages two and three agree
		st_d.s1 = pad_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.lvl = (st_q.s2 & st_q.s3) | (st_q.lvl & (st_q.s2 ^ st_q.s3));

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && st_q.awready)
		begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
			st_d.awready = 1'b0;
		end
		if (s_axi_wvalid && st_q.wready)
		begin
			st_d.w_have = 1'b1;
			st_d.wdata = s_axi_wdata;
			st_d.wstrb = s_axi_wstrb;
			st_d.wready = 1'b0;
		end
		if (st_q.aw_have && st_q.w_have && !st_q.bvalid)
		begin
			st_d.aw_have = 1'b0;
			st_d.w_have = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = `RESP_OKAY;
			if (hit(st_q.aw_addr, `GP_OUT))
				st_d.out = merge(st_q.out, st_q.wdata, wm);
			else if (hit(st_q.aw_addr, `GP_MASK))
				st_d.mask = merge(st_q.mask, st_q.wdata, wm);
			else if (hit(st_q.aw_addr, `GP_MPORT))
				st_d.out = merge(st_q.out, st_q.wdata, wm & ~st_q.mask);
			else if (hit(st_q.aw_addr, `GP_SET))
				st_d.out = st_q.out | (st_q.wdata & wm);
			else if (hit(st_q.aw_addr, `GP_CLR))
				st_d.out = st_q.out & ~(st_q.wdata & wm);
			else if (hit(st_q.aw_addr, `GP_NOT))
				st_d.out = st_q.out ^ (st_q.wdata & wm);
			else if (hit(st_q.aw_addr, `GP_DIR))
				st_d.dir = merge(st_q.dir, st_q.wdata, wm);
			else if (hit(st_q.aw_addr, `GP_DIRSET))
				st_d.dir = st_q.dir | (st_q.wdata & wm);
			else if (hit(st_q.aw_addr, `GP_DIRCLR))
				st_d.dir = st_q.dir & ~(st_q.wdata & wm);
			else if (hit(st_q.aw_addr, `GP_DIRNOT))
				st_d.dir = st_q.dir ^ (st_q.wdata & wm);
			else if (hit(st_q.aw_addr, `GP_PIN))
				st_d.bresp = `RESP_OKAY;
			else if (hit(st_q.aw_addr, `GP_GPEN))
				st_d.gpen = merge(st_q.gpen, st_q.wdata, wm);
			else if (hit(st_q.aw_addr, `GP_FIXEN))
				st_d.fixen = merge(st_q.fixen, st_q.wdata, wm);
			else if (hit(st_q.aw_addr, `GP_ANA))
				st_d.ana = merge(st_q.ana, st_q.wdata, wm);
			else if (hit(st_q.aw_addr, `GP_FDIV))
				st_d.fdiv = merge(st_q.fdiv, st_q.wdata, wm);
			else if (st_q.aw_addr[11:5] == {2'h0, `GP_MOV_BASE})
			begin
				if (st_q.wstrb[0])
					st_d.mov[st_q.aw_addr[4:2]] = st_q.wdata[7:0];
			end
			else if (st_q.aw_addr[11:4] == {2'h0, `GP_TSEL_BASE})
			begin
				if (st_q.wstrb[0])
					st_d.tsel[st_q.aw_addr[3:2]] = st_q.wdata[1:0];
			end
			else if (st_q.aw_addr[11:7] == `GP_CFG_BASE)
				st_d.cfg[st_q.aw_addr[6:2]] = (st_q.cfg[st_q.aw_addr[6:2]] & ~wm[11:0])
					| (st_q.wdata[11:0] & wm[11:0]);
			else
				st_d.bresp = `RESP_SLVERR;
		end
		if (st_q.bvalid && s_axi_bready)
		begin
			st_d.bvalid = 1'b0;
			st_d.awready = 1'b1;
			st_d.wready = 1'b1;
		end

		// Read channel: data one cycle after the address is taken
		if (s_axi_arvalid && st_q.arready)
		begin
			st_d.arready = 1'b0;
			st_d.rvalid = 1'b1;
			st_d.rresp = `RESP_OKAY;
			st_d.rdata = 32'h0000_0000;
			if (hit(s_axi_araddr, `GP_OUT))
				st_d.rdata = st_q.out;
			else if (hit(s_axi_araddr, `GP_MASK))
				st_d.rdata = st_q.mask;
			else if (hit(s_axi_araddr, `GP_MPORT))
				st_d.rdata = pin_val & ~st_q.mask;
			else if (hit(s_axi_araddr, `GP_SET))
				st_d.rdata = st_q.out;
			else if (hit(s_axi_araddr, `GP_DIR))
				st_d.rdata = st_q.dir;
			else if (hit(s_axi_araddr, `GP_PIN))
				st_d.rdata = pin_val;
			else if (hit(s_axi_araddr, `GP_GPEN))
				st_d.rdata = st_q.gpen;
			else if (hit(s_axi_araddr, `GP_FIXEN))
				st_d.rdata = st_q.fixen;
			else if (hit(s_axi_araddr, `GP_ANA))
				st_d.rdata = st_q.ana;
			else if (hit(s_axi_araddr, `GP_FDIV))
				st_d.rdata = st_q.fdiv;
			else if (s_axi_araddr[11:5] == {2'h0, `GP_MOV_BASE})
				st_d.rdata = {24'h0, st_q.mov[s_axi_araddr[4:2]]};
			else if (s_axi_araddr[11:4] == {2'h0, `GP_TSEL_BASE})
				st_d.rdata = {30'h0, st_q.tsel[s_axi_araddr[3:2]]};
			else if (s_axi_araddr[11:7] == `GP_CFG_BASE)
				st_d.rdata = {20'h0, st_q.cfg[s_axi_araddr[6:2]]};
			else if (!(hit(s_axi_araddr, `GP_CLR) || hit(s_axi_araddr, `GP_NOT)
				|| hit(s_axi_araddr, `GP_DIRSET) || hit(s_axi_araddr, `GP_DIRCLR)
				|| hit(s_axi_araddr, `GP_DIRNOT)))
				st_d.rresp = `RESP_SLVERR;
		end
		if (st_q.rvalid && s_axi_rready)
		begin
			st_d.rvalid = 1'b0;
			st_d.arready = 1'b1;
		end

		// Peripheral inputs follow the pin each function is routed to
		for (int k = 0; k < 8; k++)
			st_d.mov_in[k] = ~st_q.mov[k][7] & pin_val[st_q.mov[k][4:0]];
		for (int k = 0; k < 4; k++)
		begin
			tc = tmr_cand(2'(k), st_q.tsel[k]);
			st_d.tmr_in[k] = tc[5] & pin_val[tc[4:0]];
		end

		// -------------------------------------------------------------
		// Pad drive: analog, then fixed, then routed, then port function
		// -------------------------------------------------------------
		for (int p = 0; p < 32; p++)
		begin
			o = st_q.out[p];
			e = st_q.gpen[p] & st_q.dir[p];
			for (int k = 0; k < 4; k++)
			begin
				tc = tmr_cand(2'(k), st_q.tsel[k]);
				if (tc[5] && tc[4:0] == 5'(p))
				begin
					o = tmr_out[k];
					e = tmr_oe[k];
				end
			end
			for (int k = 0; k < 8; k++)
			begin
				if (!st_q.mov[k][7] && st_q.mov[k][4:0] == 5'(p))
				begin
					o = mov_out[k];
					e = mov_oe[k];
				end
			end
			if (st_q.fixen[p] || st_q.ana[p])
				e = 1'b0;
			if (st_q.cfg[p].od || p == `OD_PIN_A || p == `OD_PIN_B)
			begin
				e = e & ~o;
				o = 1'b0;
			end
			st_d.pad_out[p] = o;
			st_d.pad_oe[p] = e;
			st_d.pad_pu[p] = st_q.cfg[p].rep ? st_q.lvl[p] : st_q.cfg[p].pu;
			st_d.pad_pd[p] = st_q.cfg[p].rep ? ~st_q.lvl[p] : st_q.cfg[p].pd;
			if (st_q.ana[p] || p == `OD_PIN_A || p == `OD_PIN_B)
			begin
				st_d.pad_pu[p] = 1'b0;
				st_d.pad_pd[p] = 1'b0;
			end
			st_d.pad_hys[p] = st_q.cfg[p].hys;
		end
		st_d.i2c = {st_q.cfg[`OD_PIN_B].i2c, st_q.cfg[`OD_PIN_A].i2c};
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_q <= st_reset();
		else
			st_q <= st_d;
	end

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	assign s_axi_awready = st_q.awready;
	assign s_axi_wready = st_q.wready;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rresp = st_q.rresp;
	assign s_axi_rdata = st_q.rdata;
	assign pad_out = st_q.pad_out;
	assign pad_oe = st_q.pad_oe;
	assign pad_pu = st_q.pad_pu;
	assign pad_pd = st_q.pad_pd;
	assign pad_hys = st_q.pad_hys;
	assign pad_ana = st_q.ana;
	assign fix_en = st_q.fixen;
	assign od_i2c_mode = st_q.i2c;
	assign mov_in = st_q.mov_in;
	assign tmr_in = st_q.tmr_in;
endmodule

// *** testbench/gpio_props_properties.sv ***
// Port-level assertions for the GPIO block
`timescale 1ns/100ps
module gpio_props
	import gpio_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] pad_out,
	input wire logic [31:0] pad_oe,
	input wire logic [31:0] pad_pu,
	input wire logic [31:0] pad_ana,
	input wire logic [31:0] fix_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read response missing");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while busy");
	AST_RST_PU: assert property ($fell(sys_rst) |-> ##[0:3] pad_pu == 32'hffff_f3ff)
		else $error("pull-ups wrong after reset");
	AST_OD_NOPULL: assert property (pad_pu[11:10] == 2'h0)
		else $error("open-drain pin pulled up");
	AST_OD_LOW: assert property ((pad_oe & pad_out & 32'h0000_0c00) == 32'h0)
		else $error("open-drain pin driven high");
	AST_ANA_OFF: assert property ((pad_ana & $past(pad_ana) & (pad_oe | pad_pu)) == 32'h0)
		else $error("analog pin still digital");
	AST_FIX_OFF: assert property ((fix_en & $past(fix_en) & pad_oe) == 32'h0)
		else $error("fixed pin driven by port");
endmodule
bind gpio_pin_config_switch_matrix gpio_props gpio_props_i (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pad_out, .pad_oe, .pad_pu, .pad_ana, .fix_en);

// *** testbench/pin_side_model.sv ***
// Pads and board seen by the block: drivers, pulls and floating lines
`timescale 1ns/100ps
module pin_side_model
(
	input  wire logic        clk,
	input  wire logic [31:0] pad_out,
	input  wire logic [31:0] pad_oe,
	input  wire logic [31:0] pad_pu,
	input  wire logic [31:0] pad_pd,
	input  wire logic [31:0] ext_en,
	input  wire logic [31:0] ext_val,
	output logic      [31:0] pad_in
);
	logic [31:0] float_q = 32'h5555_5555;
	// Undriven, unpulled lines wander so a stale level never passes
	always_ff @(posedge clk)
	begin
		float_q <= ~float_q;
	end
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (~pad_oe & ~ext_en & (pad_pu | (~pad_pd & float_q)));
endmodule

// *** testbench/gpio_pin_config_switch_matrix_tb.sv ***
// Self-checking bench for the GPIO port, pin configuration and router
`timescale 1ns/100ps
`include "gpio_map.svh"
module gpio_pin_config_switch_matrix_tb;
	logic        clk = 1'b0, sys_rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, ext_en = 32'h0, ext_val = 32'h0, rdat;
	logic [3:0]  s_axi_wstrb = 4'hf, tmr_out = 4'h0, tmr_oe = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  mov_out = 8'h00, mov_oe = 8'h00;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata, pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_hys, pad_ana, fix_en;
	wire logic [3:0]  od_i2c_mode, tmr_in;
	wire logic [7:0]  mov_in;
	int errors = 0;
	int num_checks = 0;
	gpio_pin_config_switch_matrix gpio_pin_config_switch_matrix_i (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pad_in, .pad_out, .pad_oe, .pad_pu, .pad_pd, .pad_hys, .pad_ana, .fix_en, .od_i2c_mode,
		.mov_out, .mov_oe, .mov_in, .tmr_out, .tmr_oe, .tmr_in);
	pin_side_model pin_side_model_i (.clk, .pad_out, .pad_oe, .pad_pu, .pad_pd, .ext_en, .ext_val, .pad_in);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_t, w_t, b_t;
		logic [1:0] br;
		int n;
		b_t = 1'b0;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_t && n < 50)
		begin
			@(negedge clk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			br = s_axi_bresp;
			n++;
			@(posedge clk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk("bresp", {29'h0, 1'b1, er}, {29'h0, b_t, br});
	endtask
	task automatic axi_rd(input logic [11:0] a, input logic [1:0] er);
		logic ar_t, r_t;
		logic [1:0] rr;
		int n;
		r_t = 1'b0;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_t && n < 50)
		begin
			@(negedge clk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			rr = s_axi_rresp;
			rdat = s_axi_rdata;
			n++;
			@(posedge clk);
			if (ar_t)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk("rresp", {29'h0, 1'b1, er}, {29'h0, r_t, rr});
	endtask
	task automatic settle();
		repeat (8) @(posedge clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		axi_rd(`GP_DIR, `RESP_OKAY);
		chk("dir", 32'h0, rdat);
		axi_rd(`GP_GPEN, `RESP_OKAY);
		chk("gpen", ~32'h0000_002c, rdat);
		axi_rd(`GP_FIXEN, `RESP_OKAY);
		chk("fixen", 32'h0000_002c, rdat);
		chk("pad_oe", 32'h0, pad_oe);
		chk("pad_pu", 32'hffff_f3ff, pad_pu);
	endtask
	task automatic t_port();
		axi_wr(`GP_DIR, 32'h000f_0000, `RESP_OKAY);
		axi_wr(`GP_OUT, 32'h0005_0000, `RESP_OKAY);
		settle();
		chk("pad_oe", 32'h000f_0000, pad_oe);
		chk("pad_out", 32'h0005_0000, pad_out & 32'h000f_0000);
		axi_wr(`GP_SET, 32'h000a_0000, `RESP_OKAY);
		axi_rd(`GP_OUT, `RESP_OKAY);
		chk("out set", 32'h000f_0000, rdat);
		axi_wr(`GP_CLR, 32'h0003_0000, `RESP_OKAY);
		axi_rd(`GP_OUT, `RESP_OKAY);
		chk("out clr", 32'h000c_0000, rdat);
		axi_wr(`GP_NOT, 32'h000f_0000, `RESP_OKAY);
		axi_rd(`GP_OUT, `RESP_OKAY);
		chk("out not", 32'h0003_0000, rdat);
		axi_wr(`GP_MASK, ~32'h0001_0000, `RESP_OKAY);
		axi_wr(`GP_MPORT, 32'h0, `RESP_OKAY);
		axi_rd(`GP_OUT, `RESP_OKAY);
		chk("out masked", 32'h0002_0000, rdat);
		settle();
		chk("pad_out", 32'h0002_0000, pad_out & 32'h000f_0000);
	endtask
	task automatic t_dir_pin();
		axi_wr(`GP_DIRSET, 32'h0010_0000, `RESP_OKAY);
		axi_rd(`GP_DIR, `RESP_OKAY);
		chk("dirset", 32'h001f_0000, rdat);
		axi_wr(`GP_DIRCLR, 32'h0001_0000, `RESP_OKAY);
		axi_rd(`GP_DIR, `RESP_OKAY);
		chk("dirclr", 32'h001e_0000, rdat);
		axi_wr(`GP_DIRNOT, 32'h0003_0000, `RESP_OKAY);
		axi_rd(`GP_DIR, `RESP_OKAY);
		chk("dirnot", 32'h001d_0000, rdat);
		ext_en <= 32'h0100_0000;
		ext_val <= 32'h0100_0000;
		settle();
		axi_rd(`GP_PIN, `RESP_OKAY);
		chk("pin", 32'h0102_0000, rdat & 32'h011f_0000);
		axi_wr(12'h0e0, 32'h0000_0011, `RESP_OKAY);
		settle();
		axi_rd(`GP_PIN, `RESP_OKAY);
		chk("pin inv", 32'h0002_0000, rdat & 32'h011f_0000);
		axi_wr(`GP_FDIV, 32'h0000_ff00, `RESP_OKAY);
		axi_wr(12'h0e0, 32'h0000_01c1, `RESP_OKAY);
		ext_val <= 32'h0;
		settle();
		axi_rd(`GP_PIN, `RESP_OKAY);
		chk("pin held", 32'h0100_0000, rdat & 32'h0100_0000);
		repeat (900) @(posedge clk);
		axi_rd(`GP_PIN, `RESP_OKAY);
		chk("pin filtered", 32'h0, rdat & 32'h0100_0000);
	endtask
	task automatic t_cfg_od();
		axi_wr(12'h0d4, 32'h0000_0022, `RESP_OKAY);
		settle();
		chk("cfg pd hys", 32'h6, {29'h0, pad_hys[21], pad_pd[21], pad_pu[21]});
		axi_wr(12'h0d4, 32'h0000_0001, `RESP_OKAY);
		settle();
		chk("cfg pu", 32'h1, {29'h0, pad_hys[21], pad_pd[21], pad_pu[21]});
		axi_wr(12'h0d4, 32'h0000_0008, `RESP_OKAY);
		ext_en <= 32'h0120_0000;
		settle();
		ext_en <= 32'h0100_0000;
		settle();
		chk("repeater", 32'h2, {30'h0, pad_pd[21], pad_pu[21]});
		axi_wr(`GP_DIRSET, 32'h0000_0400, `RESP_OKAY);
		axi_wr(`GP_SET, 32'h0000_0400, `RESP_OKAY);
		settle();
		chk("od high", 32'h0, {31'h0, pad_oe[10]});
		axi_wr(`GP_CLR, 32'h0000_0400, `RESP_OKAY);
		settle();
		chk("od low", 32'h2, {30'h0, pad_oe[10], pad_out[10]});
		for (int m = 0; m < 3; m++)
		begin
			axi_wr(12'h0a8, 32'(m) << 10, `RESP_OKAY);
			axi_wr(12'h0ac, 32'(m) << 10, `RESP_OKAY);
			settle();
			chk("i2c mode", 32'(m) * 32'h5, {28'h0, od_i2c_mode});
		end
	endtask
	task automatic t_route();
		axi_wr(12'h040, 32'h0000_0016, `RESP_OKAY);
		mov_out <= 8'h01;
		mov_oe <= 8'h01;
		settle();
		chk("movable", 32'h7, {29'h0, pad_oe[22], pad_out[22], mov_in[0]});
		axi_wr(`GP_FIXEN, 32'h0040_002c, `RESP_OKAY);
		settle();
		chk("fixed", 32'h0, {31'h0, pad_oe[22]});
		chk("fix_en", 32'h0040_002c, fix_en);
		axi_wr(`GP_FIXEN, 32'h0000_002c, `RESP_OKAY);
		axi_wr(`GP_ANA, 32'h0002_0000, `RESP_OKAY);
		settle();
		axi_rd(`GP_PIN, `RESP_OKAY);
		chk("analog", 32'h0, {30'h0, rdat[17], pad_pu[17]});
		chk("pad_ana", 32'h0002_0000, pad_ana);
		axi_wr(12'h060, 32'h0000_0001, `RESP_OKAY);
		tmr_out <= 4'h1;
		tmr_oe <= 4'h1;
		settle();
		chk("timer sel", 32'h7, {29'h0, pad_oe[12], pad_out[12], tmr_in[0]});
		axi_wr(12'h060, 32'h0000_0003, `RESP_OKAY);
		settle();
		chk("timer off", 32'h0, {30'h0, pad_oe[12], tmr_in[0]});
		axi_wr(`GP_GPEN, 32'hfffe_ffd3, `RESP_OKAY);
		settle();
		chk("gpen off", 32'h2, {30'h0, pad_oe[18], pad_oe[16]});
	endtask
	task automatic t_bad();
		axi_wr(12'h03c, 32'hffff_ffff, `RESP_SLVERR);
		axi_rd(12'h03c, `RESP_SLVERR);
		chk("unmapped", 32'h0, rdat);
		axi_wr(`GP_PIN, 32'h0, `RESP_OKAY);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Run
	// ----------------------------------------
	initial
	begin
		forever #5 clk = ~clk;
	end
	initial
	begin
		#300_000;
		errors++;
		tally_and_finish();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		t_port();
		t_dir_pin();
		t_cfg_od();
		t_route();
		t_bad();
		tally_and_finish();
	end
endmodule
